// ### src/rsl_pkg.sv
// Purpose: Shared constants and types for the reset strap latch.
// Assumes: Straps sit on shared bus address/data pins 31 down to 26.
// Notes:   Status register bits mirror the strap pin positions.
`default_nettype none

package rsl_pkg;

   // ---------------------------------------------------------------
   // Strap pin positions
   // ---------------------------------------------------------------
   localparam int unsigned STRAP_MSB = 31;
   localparam int unsigned STRAP_LSB = 26;
   localparam int unsigned STRAP_W = STRAP_MSB - STRAP_LSB + 1;
   localparam int unsigned POS_RATE_HI = 31;
   localparam int unsigned POS_RATE_LO = 30;
   localparam int unsigned POS_OSC_HOLD = 29;
   localparam int unsigned POS_RANGE = 28;
   localparam int unsigned POS_LEN_HI = 27;
   localparam int unsigned POS_LEN_LO = 26;

   // ---------------------------------------------------------------
   // Configuration status register
   // ---------------------------------------------------------------
   localparam logic [7:0] STRAP_CONFIG_STATUS_OFFSET = 8'h88;
   localparam logic [31:0] STRAP_CONFIG_STATUS_RESET = 32'h0000_0000;

   // ---------------------------------------------------------------
   // Strap encodings
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      RATE_100MHZ = 2'b00,
      RATE_66MHZ_DEBUG = 2'b01,
      RATE_RESERVED = 2'b10,
      RATE_133MHZ = 2'b11
   } rsl_rate_e;

   typedef enum logic [1:0] {
      LEN_SHORT_NON_SLOT = 2'b00,
      LEN_SINGLE_OR_CLOSE = 2'b01,
      LEN_FAR_DUAL = 2'b10,
      LEN_FARTHEST = 2'b11
   } rsl_len_e;

   // Low selects 0.6 V to 1.0 V sensing, high selects 1.0 V to 1.4 V
   localparam logic RANGE_LOW_WINDOW = 1'b0;
   localparam logic RANGE_HIGH_WINDOW = 1'b1;

   // Defaults held until the first capture after reset release
   localparam logic [STRAP_W-1:0] STRAP_DEFAULT = 6'h08;

   // ---------------------------------------------------------------
   // Initialization stream
   // ---------------------------------------------------------------
   localparam int unsigned INIT_STREAM_LEN = 16;
   localparam logic [7:0] INIT_STREAM_HEADER = 8'hA5;
   localparam int unsigned INIT_HEADER_W = 8;
   localparam int unsigned INIT_POS_RATE = 8;
   localparam int unsigned INIT_POS_RANGE = 10;
   localparam int unsigned INIT_POS_LEN = 11;
   localparam int unsigned INIT_POS_DEBUG = 13;
   localparam int unsigned INIT_POS_RESV = 14;

   typedef enum logic [1:0] {
      STREAM_WAIT = 2'b00,
      STREAM_SEND = 2'b01,
      STREAM_DONE = 2'b11
   } rsl_stream_e;

endpackage : rsl_pkg

`default_nettype wire

// ### src/rsl_strap_if.sv
// Purpose: Carries captured strap values from the sampler to the top.
// Assumes: One clock domain.
// Notes:   Valid rises once per reset and stays high.
`default_nettype none

interface rsl_strap_if;
   logic [rsl_pkg::STRAP_W-1:0] straps;
   logic valid;
   logic capture;

   modport src (output straps, output valid, output capture);
   modport sink (input straps, input valid, input capture);
endinterface : rsl_strap_if

`default_nettype wire

// ### src/rsl_strap_sampler.sv
// Purpose: Synchronises the strap pins and latches them once per reset.
// Assumes: Board keeps the straps steady through reset and its release.
// Notes:   Synchroniser flops run through reset so they hold pin levels.
`default_nettype none

module rsl_strap_sampler (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Strap pins
   input wire logic [rsl_pkg::STRAP_W-1:0] strap_pins,
   // Captured values
   rsl_strap_if.src cap
);

   // ---------------------------------------------------------------
   // Two-stage synchroniser, sampling while reset is held
   // ---------------------------------------------------------------
   logic [rsl_pkg::STRAP_W-1:0] sync1_q;
   logic [rsl_pkg::STRAP_W-1:0] sync2_q;

   always_ff @(posedge mclk) begin
      sync1_q <= strap_pins; // [RQ1]
      sync2_q <= sync1_q;
   end

   // ---------------------------------------------------------------
   // Single capture at the first edge after release
   // ---------------------------------------------------------------
   logic pending_q;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pending_q <= 1'b1;
      end else begin
         pending_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cap.straps <= rsl_pkg::STRAP_DEFAULT;
         cap.valid <= 1'b0;
         cap.capture <= 1'b0;
      end else begin
         cap.capture <= pending_q;
         if (pending_q) begin
            cap.straps <= sync2_q; // [RQ1]
            cap.valid <= 1'b1;
         end
         // Later bus activity never reaches the held values [RQ10]
      end
   end

endmodule : rsl_strap_sampler

`default_nettype wire

// ### src/rsl_reset_strap_latch.sv
// Purpose: Latches configuration straps at reset and publishes them.
// Assumes: Pull resistors set the shared bus pins during reset.
// Notes:   Status register is a read-only port image at its offset.
//
// How it works
// [RQ1] Sample straps in reset, hold after release
// [RQ2] High enables option, low disables it
// [RQ3] Expose latched fields in status register
// [RQ4] Straps shape the processor initialization stream
// [RQ5] Pins 31:30 choose bus clock rate
// [RQ6] 66 MHz encoding is debug only
// [RQ7] Board holds pin 29 low for bypass
// [RQ8] Pin 28 picks clock receiver range
// [RQ9] Pins 27:26 classify first processor bus
// [RQ10] Latched values constant until next reset
`default_nettype none

module rsl_reset_strap_latch #(
   parameter int unsigned STREAM_LEN = rsl_pkg::INIT_STREAM_LEN
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Strap pins on the shared bus
   input wire logic [rsl_pkg::STRAP_MSB:rsl_pkg::STRAP_LSB] bus_ad_pins,
   // Operating configuration
   output logic [1:0] bus_clock_rate_select,
   output logic rate_debug_only,
   output logic rate_reserved,
   output logic osc_hold_n,
   output logic clock_receiver_range_select,
   output logic [1:0] bus_length_class,
   output logic config_valid,
   // Configuration status register image
   output logic [31:0] strap_config_status,
   // Processor initialization stream
   output logic processor_init_stream,
   output logic processor_init_stream_valid,
   output logic processor_init_stream_done
);

   // ---------------------------------------------------------------
   // Parameter check
   // ---------------------------------------------------------------
   localparam int unsigned STREAM_MIN = 16;
   localparam int unsigned STREAM_MAX = 64;

   generate
      if (STREAM_LEN < STREAM_MIN || STREAM_LEN > STREAM_MAX) begin : g_bad_len
         $error("STREAM_LEN must lie between 16 and 64");
      end
   endgenerate

   localparam int unsigned CNT_W = $clog2(STREAM_LEN + 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STREAM_LEN - 1);

   // ---------------------------------------------------------------
   // Strap capture
   // ---------------------------------------------------------------
   rsl_strap_if cap_if ();

   rsl_strap_sampler u_sampler (
      .mclk(mclk),
      .resetn(resetn),
      .strap_pins(bus_ad_pins),
      .cap(cap_if.src)
   );

   localparam int unsigned IX_RATE_HI = rsl_pkg::POS_RATE_HI - rsl_pkg::STRAP_LSB;
   localparam int unsigned IX_RATE_LO = rsl_pkg::POS_RATE_LO - rsl_pkg::STRAP_LSB;
   localparam int unsigned IX_OSC = rsl_pkg::POS_OSC_HOLD - rsl_pkg::STRAP_LSB;
   localparam int unsigned IX_RANGE = rsl_pkg::POS_RANGE - rsl_pkg::STRAP_LSB;
   localparam int unsigned IX_LEN_HI = rsl_pkg::POS_LEN_HI - rsl_pkg::STRAP_LSB;
   localparam int unsigned IX_LEN_LO = rsl_pkg::POS_LEN_LO - rsl_pkg::STRAP_LSB;

   logic [1:0] rate_d;
   logic [1:0] len_d;
   logic range_d;
   logic osc_d;

   // Fields are only taken up in the cycle that capture is high
   always_comb begin
      rate_d = {cap_if.straps[IX_RATE_HI], cap_if.straps[IX_RATE_LO]}; // [RQ5]
      len_d = {cap_if.straps[IX_LEN_HI], cap_if.straps[IX_LEN_LO]}; // [RQ9]
      range_d = cap_if.straps[IX_RANGE]; // [RQ8]
      osc_d = cap_if.straps[IX_OSC]; // [RQ2]
   end

   // ---------------------------------------------------------------
   // Operating configuration outputs
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         bus_clock_rate_select <= rsl_pkg::RATE_100MHZ;
         clock_receiver_range_select <= rsl_pkg::RANGE_LOW_WINDOW;
         bus_length_class <= rsl_pkg::LEN_SHORT_NON_SLOT;
         osc_hold_n <= 1'b1;
         config_valid <= 1'b0;
      end else if (cap_if.capture) begin
         bus_clock_rate_select <= rate_d; // [RQ5]
         clock_receiver_range_select <= range_d; // [RQ8]
         bus_length_class <= len_d; // [RQ9]
         // High level keeps the oscillator running; low means bypass [RQ2] [RQ7]
         osc_hold_n <= osc_d;
         config_valid <= cap_if.valid; // [RQ1]
      end
      // Otherwise every value holds until the next reset [RQ10]
   end

   // Flags warn firmware that the rate is not for normal operation
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rate_debug_only <= 1'b0;
         rate_reserved <= 1'b0;
      end else if (cap_if.capture) begin
         rate_debug_only <= (rate_d == rsl_pkg::RATE_66MHZ_DEBUG); // [RQ6]
         rate_reserved <= (rate_d == rsl_pkg::RATE_RESERVED); // [RQ5]
      end
   end

   // ---------------------------------------------------------------
   // Configuration status register
   // ---------------------------------------------------------------
   logic [31:0] status_d;

   always_comb begin
      status_d = rsl_pkg::STRAP_CONFIG_STATUS_RESET;
      status_d[rsl_pkg::POS_RATE_HI:rsl_pkg::POS_RATE_LO] = rate_d; // [RQ3]
      status_d[rsl_pkg::POS_OSC_HOLD] = osc_d;
      status_d[rsl_pkg::POS_RANGE] = range_d; // [RQ3]
      status_d[rsl_pkg::POS_LEN_HI:rsl_pkg::POS_LEN_LO] = len_d; // [RQ3]
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         strap_config_status <= rsl_pkg::STRAP_CONFIG_STATUS_RESET;
      end else if (cap_if.capture) begin
         strap_config_status <= status_d; // [RQ3] [RQ10]
      end
   end

   // ---------------------------------------------------------------
   // Initialization stream word
   // ---------------------------------------------------------------
   // Header, then rate, range, length, debug flag, reserved flag, parity
   logic [STREAM_LEN-1:0] word_d;
   logic [STREAM_LEN-1:0] word_q;

   always_comb begin
      word_d = '0;
      word_d[rsl_pkg::INIT_HEADER_W-1:0] = rsl_pkg::INIT_STREAM_HEADER;
      word_d[rsl_pkg::INIT_POS_RATE +: 2] = rate_d; // [RQ4]
      word_d[rsl_pkg::INIT_POS_RANGE] = range_d; // [RQ4]
      word_d[rsl_pkg::INIT_POS_LEN +: 2] = len_d; // [RQ4]
      word_d[rsl_pkg::INIT_POS_DEBUG] = (rate_d == rsl_pkg::RATE_66MHZ_DEBUG); // [RQ6]
      word_d[rsl_pkg::INIT_POS_RESV] = (rate_d == rsl_pkg::RATE_RESERVED);
      word_d[STREAM_LEN-1] = ^word_d[STREAM_LEN-2:0];
   end

   // ---------------------------------------------------------------
   // Initialization stream serializer
   // ---------------------------------------------------------------
   // Bit 0 leaves first; zeros fill in behind the word
   rsl_pkg::rsl_stream_e state_q;
   logic [CNT_W-1:0] bit_cnt_q;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_q <= rsl_pkg::STREAM_WAIT;
      end else begin
         unique case (state_q)
            rsl_pkg::STREAM_WAIT: begin
               if (cap_if.capture) begin
                  state_q <= rsl_pkg::STREAM_SEND;
               end
            end
            rsl_pkg::STREAM_SEND: begin
               if (bit_cnt_q == CNT_LAST) begin
                  state_q <= rsl_pkg::STREAM_DONE;
               end
            end
            rsl_pkg::STREAM_DONE: begin
               state_q <= rsl_pkg::STREAM_DONE;
            end
            default: begin
               state_q <= rsl_pkg::STREAM_WAIT;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         word_q <= '0;
         bit_cnt_q <= CNT_ZERO;
      end else if (state_q == rsl_pkg::STREAM_WAIT && cap_if.capture) begin
         word_q <= word_d; // [RQ4]
         bit_cnt_q <= CNT_ZERO;
      end else if (state_q == rsl_pkg::STREAM_SEND) begin
         word_q <= {1'b0, word_q[STREAM_LEN-1:1]};
         bit_cnt_q <= bit_cnt_q + CNT_ONE;
      end
   end

   // Valid rises one edge after the word loads
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         processor_init_stream <= 1'b0;
         processor_init_stream_valid <= 1'b0;
         processor_init_stream_done <= 1'b0;
      end else begin
         processor_init_stream <= (state_q == rsl_pkg::STREAM_SEND) & word_q[0]; // [RQ4]
         processor_init_stream_valid <= (state_q == rsl_pkg::STREAM_SEND);
         processor_init_stream_done <= (state_q == rsl_pkg::STREAM_DONE);
      end
   end

endmodule : rsl_reset_strap_latch

`default_nettype wire

// ### testbench/rsl_assertions.sv
// Purpose: Port checks for the reset strap latch.
// Assumes: One clock, resetn async low.
// Notes:   Bound to the top module.
`default_nettype none
module rsl_assertions (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Straps and config
   input wire logic [31:26] bus_ad_pins,
   input wire logic [1:0] bus_clock_rate_select,
   input wire logic rate_debug_only,
   input wire logic rate_reserved,
   input wire logic osc_hold_n,
   input wire logic clock_receiver_range_select,
   input wire logic [1:0] bus_length_class,
   input wire logic config_valid,
   input wire logic [31:0] strap_config_status,
   // Stream
   input wire logic processor_init_stream,
   input wire logic processor_init_stream_valid,
   input wire logic processor_init_stream_done
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic [31:0] st = strap_config_status;
   wire logic v = processor_init_stream_valid;
   wire logic [1:0] r = bus_clock_rate_select;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   chk_rate_map: assert property (config_valid |-> st[31:30] == r)
      else $error("rate field mismatch");
   chk_debug_flag: assert property (rate_debug_only == (r == 2'b01))
      else $error("debug flag mismatch");
   chk_resv_flag: assert property (rate_reserved == (r == 2'b10))
      else $error("reserved flag mismatch");
   chk_range_osc: assert property (
      config_valid |-> st[29] == osc_hold_n && st[28] == clock_receiver_range_select)
      else $error("range or osc bit mismatch");
   chk_len_map: assert property (config_valid |-> st[27:26] == bus_length_class)
      else $error("length field mismatch");
   chk_status_low: assert property (st[25:0] == 26'h000_0000)
      else $error("status low bits set");
   chk_capture_value: assert property (
      $rose(config_valid) |-> st[31:26] == $past(bus_ad_pins, 4))
      else $error("captured value wrong");
   chk_hold_steady: assert property (
      config_valid && $past(config_valid) |-> $stable(st) && $stable(r))
      else $error("latched value moved");
   chk_stream_start: assert property ($rose(config_valid) |-> ##1 $rose(v))
      else $error("stream start late");
   chk_stream_len: assert property (
      $rose(v) |-> v [*8] ##1 v [*8] ##1 (!v && processor_init_stream_done))
      else $error("stream length wrong");
   chk_stream_idle: assert property (!v |-> !processor_init_stream)
      else $error("stream bit outside frame");
endmodule : rsl_assertions
bind rsl_reset_strap_latch rsl_assertions chk_i (.*);
`default_nettype wire

// ### testbench/rsl_board_pulls.sv
// Purpose: Board pulls on the shared strap pins, then bus traffic.
// Assumes: Pulls hold the pins through reset and four edges after.
// Notes:   Traffic pattern changes every cycle.
`default_nettype none
module rsl_board_pulls (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Board strap setting
   input wire logic [5:0] strap_set,
   // Shared bus pins
   output logic [31:26] bus_ad_pins
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] run_q;
   logic [5:0] trf_q;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         run_q <= 3'h0;
         trf_q <= ~strap_set;
      end else begin
         if (run_q != 3'h4) run_q <= run_q + 3'h1;
         trf_q <= ~trf_q ^ 6'h15;
      end
   end
   // Osc hold low only in bypass cases; debug rate only in test cases
   always_comb bus_ad_pins = (run_q < 3'h4) ? strap_set : trf_q;
endmodule : rsl_board_pulls
`default_nettype wire

// ### testbench/tb_top.sv
// Purpose: Self-checking bench for the reset strap latch.
// Assumes: Straps set before each reset.
// Notes:   Four strap codes are latched in scn_decode; two of them again in scn_hold.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic [5:0] strap_set = 6'h08;
   logic [31:26] pins;
   logic [1:0] rate, len;
   logic dbg, rsv, osc, rng, cfg, sd, sv, sdn;
   logic [31:0] st;
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;
   always #4 mclk = ~mclk;
   rsl_board_pulls brd (.mclk(mclk), .resetn(resetn), .strap_set(strap_set),
      .bus_ad_pins(pins));
   rsl_reset_strap_latch #(.STREAM_LEN(16)) dut (.mclk(mclk), .resetn(resetn),
      .bus_ad_pins(pins), .bus_clock_rate_select(rate), .rate_debug_only(dbg),
      .rate_reserved(rsv), .osc_hold_n(osc), .clock_receiver_range_select(rng),
      .bus_length_class(len), .config_valid(cfg), .strap_config_status(st),
      .processor_init_stream(sd), .processor_init_stream_valid(sv),
      .processor_init_stream_done(sdn));
   // ----
   // Helpers
   // ----
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic close_out();
      $display("fails %0d of %0d checks", n_fail, n_tests);
      if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   task automatic reset_with(input logic [5:0] s);
      @(posedge mclk);
      resetn <= 1'b0;
      strap_set <= s;
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      for (int k = 0; k < 6 && cfg !== 1'b1; k++) begin
         @(posedge mclk);
         #1;
      end
   endtask : reset_with
   // ----
   // Scenarios
   // ----
   task automatic scn_decode();
      logic [5:0] tbl [4] = '{6'h08, 6'h1d, 6'h22, 6'h3f};
      logic [15:0] e, w;
      foreach (tbl[i]) begin
         reset_with(tbl[i]);
         chk("config_valid", 32'h1, cfg);
         chk("rate", tbl[i][5:4], rate);
         chk("debug", tbl[i][5:4] == 2'b01, dbg);
         chk("reserved", tbl[i][5:4] == 2'b10, rsv);
         chk("osc_hold", tbl[i][3], osc);
         chk("range", tbl[i][2], rng);
         chk("length", tbl[i][1:0], len);
         chk("status", {tbl[i], 26'h000_0000}, st);
         e = {1'b0, tbl[i][5:4] == 2'b10, tbl[i][5:4] == 2'b01, tbl[i][1:0], tbl[i][2],
            tbl[i][5:4], 8'ha5};
         e[15] = ^e[14:0];
         for (int k = 0; k < 8 && sv !== 1'b1; k++) begin
            @(posedge mclk);
            #1;
         end
         for (int b = 0; b < 16; b++) begin
            w[b] = sd;
            @(posedge mclk);
            #1;
         end
         chk("stream", e, w);
         chk("stream_done", 32'h1, {sv, sdn});
      end
   endtask : scn_decode
   task automatic scn_hold();
      reset_with(6'h1d);
      repeat (30) @(posedge mclk);
      #1;
      chk("held_status", 32'h7400_0000, st);
      chk("held_rate", 32'h1, rate);
      reset_with(6'h22);
      chk("new_status", 32'h8800_0000, st);
   endtask : scn_hold
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         $display("[FAIL] timeout exp done got hang");
         close_out();
      end
   end
   initial begin
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      scn_decode();
      scn_hold();
      close_out();
   end
endmodule : tb_top
`default_nettype wire
